// >>> sim/ict_chk.sv
// Concurrent checks on the capture timebase link
`timescale 1ns/10ps
module ict_chk
    import ict_pkg::*;
(
    // Clock and reset
    input logic             clock_i,
    input logic             sys_rst_i,
    // Link signals
    input ict_word_t        first_timer,
    input ict_word_t        third_timer,
    input logic             frame_rx,
    input logic [1:0]       capture_pin,
    input logic             third_timer_reset,
    // Capture end controls and results
    input logic [1:0][3:0]  capture_mode_select_i,
    input logic [1:0]       timer_select_third_i,
    input logic             frame_timestamp_select_i,
    input logic [1:0]       flag_clear_i,
    input logic [1:0]       pin_direction_bit_i,
    input logic [1:0]       value_wr_i,
    input logic [1:0][15:0] capture_value_o,
    input logic [1:0]       capture_irq_flag_o
);
    ict_word_t [1:0] sel_q;
    logic [1:0]      cap_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    // Selected timer and capture mode one cycle back
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_q <= '0;
            cap_q <= '0;
        end else begin
            sel_q[0] <= timer_select_third_i[0] ? third_timer : first_timer;
            sel_q[1] <= timer_select_third_i[1] ? third_timer : first_timer;
            cap_q[0] <= capture_mode_select_i[0][3:2] == 2'h1;
            cap_q[1] <= capture_mode_select_i[1][3:2] == 2'h1;
        end
    end

    chk_evt_zero_t3: assert property (third_timer_reset |=> third_timer == 16'h0000)
        else $error("third timer not cleared by special event");
    chk_evt_one_pulse: assert property (third_timer_reset |=> !third_timer_reset)
        else $error("special event pulse too long");
    chk_flag_sticky: assert property ($fell(capture_irq_flag_o[0]) |-> $past(flag_clear_i[0]))
        else $error("flag dropped without clear");
    chk_value_cause: assert property (!$stable(capture_value_o[0])
        |-> capture_irq_flag_o[0] || $past(value_wr_i[0]))
        else $error("value changed without capture or write");
    chk_cap_value_u0: assert property ($rose(capture_irq_flag_o[0]) && cap_q[0]
        |-> capture_value_o[0] == sel_q[0])
        else $error("unit 0 captured wrong timer value");
    chk_cap_value_u1: assert property ($rose(capture_irq_flag_o[1]) && cap_q[1]
        |-> capture_value_o[1] == sel_q[1])
        else $error("unit 1 captured wrong timer value");
    chk_frame_event: assert property (frame_timestamp_select_i && frame_rx
        && capture_mode_select_i[1] == 4'h5 |=> capture_irq_flag_o[1])
        else $error("received frame not captured");
    chk_pin_masked: assert property (frame_timestamp_select_i && !frame_rx
        && capture_mode_select_i[0] == 4'h6 && !capture_irq_flag_o[0]
        |=> !capture_irq_flag_o[0])
        else $error("pin event captured while frame source selected");
    chk_rise_delay: assert property (pin_direction_bit_i[0] && !frame_timestamp_select_i
        && capture_mode_select_i[0] == 4'h5 && $rose(capture_pin[0])
        |-> ##3 capture_irq_flag_o[0])
        else $error("rising edge capture late or missing");
    chk_off_quiet: assert property (capture_mode_select_i[0] == 4'h0
        && !capture_irq_flag_o[0] |=> !capture_irq_flag_o[0])
        else $error("flag set while unit off");
endmodule // ict_chk

// >>> sim/testbench.sv
// Self-checking bench for the capture timebase pair
`timescale 1ns/10ps
module testbench
    import ict_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    logic             clock_i, sys_rst_i, fts, t1wr, t3wr, adc;
    logic [1:0][3:0]  mode;
    logic [1:0]       tsel, fclr, pdir, plat, vwr, pin, fst, flag, wf, pwm, cmp;
    logic [1:0][15:0] vwd, cval, wv;
    ict_word_t        twd, t3o, t1o, m1, m3, p1, p3;
    ict_word_t [1:0]  exp_v;
    int               n_errors, n_compared, i, k, hi0, hi1;
    int               nev [4] = '{1, 1, 4, 16};

    ict_link_if link ();

    ict_capture_end u_ict_capture_end (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link(link),
        .capture_mode_select_i(mode), .timer_select_third_i(tsel),
        .frame_timestamp_select_i(fts), .flag_clear_i(fclr), .pin_direction_bit_i(pdir),
        .port_latch_i(plat), .value_wr_i(vwr), .value_wdata_i(vwd), .capture_value_o(cval),
        .capture_irq_flag_o(flag), .compare_out_o(cmp), .pwm_out_o(pwm), .adc_start_o(adc));
    ict_timebase_end #(.RX_BUFS(2)) u_ict_timebase_end (.clock_i(clock_i),
        .sys_rst_i(sys_rst_i), .link(link), .first_timer_on_i(1'b1),
        .second_timer_on_i(1'b1), .third_timer_on_i(1'b1), .second_period_i(8'h0F),
        .first_timer_wr_i(t1wr), .third_timer_wr_i(t3wr), .timer_wdata_i(twd),
        .frame_stored_i(fst), .pin_level_i(pin), .first_timer_o(t1o), .third_timer_o(t3o));
    ict_chk u_ict_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .first_timer(link.first_timer), .third_timer(link.third_timer),
        .frame_rx(link.frame_rx), .capture_pin(link.capture_pin),
        .third_timer_reset(link.third_timer_reset), .capture_mode_select_i(mode),
        .timer_select_third_i(tsel), .frame_timestamp_select_i(fts), .flag_clear_i(fclr),
        .pin_direction_bit_i(pdir), .value_wr_i(vwr), .capture_value_o(cval),
        .capture_irq_flag_o(flag));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // ************************************************************
    // Timer mirrors and capture expectation
    // ************************************************************
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            m1 <= 16'h0000;
            m3 <= 16'h0000;
        end else begin
            m1 <= t1wr ? twd : m1 + 16'h0001;
            m3 <= t3wr ? twd : (link.third_timer_reset ? 16'h0000 : m3 + 16'h0001);
        end
    end

    // Timer value of the cycle in which a capture lands
    always @(posedge clock_i) begin
        wf = flag;
        wv = cval;
        p1 = m1;
        p3 = m3;
        #1;
        for (int u = 0; u < 2; u++)
            if (flag[u] && (!wf[u] || cval[u] !== wv[u])) exp_v[u] = tsel[u] ? p3 : p1;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string nm, input ict_word_t e, input ict_word_t g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    task automatic fchk(input int u, input logic e);
        chk("flag", {15'h0000, e}, {15'h0000, flag[u]});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic setm(input ict_mode_t a, input ict_mode_t b);
        @(posedge clock_i);
        mode <= {b, a};
    endtask

    task automatic clr(input logic [1:0] m);
        @(posedge clock_i);
        fclr <= m;
        @(posedge clock_i);
        fclr <= 2'b00;
        cyc(1);
    endtask

    task automatic pulse(input logic [1:0] m);
        @(posedge clock_i);
        pin <= pin | m;
        cyc(4);
        pin <= pin & ~m;
        cyc(5);
    endtask

    task automatic frame(input logic [1:0] b);
        @(posedge clock_i);
        fst <= b;
        @(posedge clock_i);
        fst <= 2'b00;
        cyc(3);
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #60000;
        n_errors++;
        conclude();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        n_errors = 0;
        n_compared = 0;
        sys_rst_i = 1'b1;
        fts = 1'b0;
        t1wr = 1'b0;
        t3wr = 1'b0;
        twd = '0;
        mode = '0;
        tsel = '0;
        fclr = '0;
        pdir = 2'b11;
        plat = '0;
        vwr = '0;
        vwd = '0;
        pin = '0;
        fst = '0;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        twd <= 16'hFFF0;
        t1wr <= 1'b1;
        @(posedge clock_i);
        t1wr <= 1'b0;
        twd <= 16'h8000;
        t3wr <= 1'b1;
        @(posedge clock_i);
        t3wr <= 1'b0;
        for (k = 0; k < 4; k++) begin
            setm(4'h0, 4'h0);
            setm(4'(k + 4), 4'h0);
            clr(2'b11);
            for (i = 1; i < nev[k]; i++) pulse(2'b01);
            fchk(0, 1'b0);
            pulse(2'b01);
            fchk(0, 1'b1);
            chk("value", exp_v[0], cval[0]);
        end
        $display("test modes done");
        for (k = 2; k < 4; k++) begin
            @(posedge clock_i);
            tsel <= 2'(k);
            setm(4'h5, 4'h5);
            clr(2'b11);
            pulse(2'b11);
            chk("value0", exp_v[0], cval[0]);
            chk("value1", exp_v[1], cval[1]);
        end
        pulse(2'b01);
        chk("overwrite", exp_v[0], cval[0]);
        fchk(0, 1'b1);
        clr(2'b01);
        fchk(0, 1'b0);
        $display("test timers done");
        setm(4'h0, 4'h0);
        setm(4'h7, 4'h0);
        clr(2'b11);
        for (i = 0; i < 3; i++) pulse(2'b01);
        setm(4'h6, 4'h0);
        fchk(0, 1'b0);
        pulse(2'b01);
        fchk(0, 1'b1);
        setm(4'h5, 4'h0);
        clr(2'b01);
        @(posedge clock_i);
        pdir <= 2'b10;
        plat <= 2'b01;
        cyc(3);
        fchk(0, 1'b1);
        plat <= 2'b00;
        pdir <= 2'b11;
        $display("test prescale done");
        @(posedge clock_i);
        fts <= 1'b1;
        setm(4'h6, 4'h5);
        clr(2'b11);
        pulse(2'b01);
        for (i = 0; i < 3; i++) frame(i[0] ? 2'b10 : 2'b01);
        fchk(0, 1'b0);
        fchk(1, 1'b1);
        frame(2'b10);
        fchk(0, 1'b1);
        chk("stamp", exp_v[0], cval[0]);
        setm(4'h4, 4'h5);
        clr(2'b01);
        frame(2'b01);
        fchk(0, 1'b1);
        fts <= 1'b0;
        $display("test frames done");
        @(posedge clock_i);
        tsel <= 2'b11;
        vwd <= {16'h0040, 16'h0000};
        vwr <= 2'b10;
        setm(4'h5, 4'h0);
        vwr <= 2'b00;
        twd <= 16'h0000;
        t3wr <= 1'b1;
        setm(4'h5, 4'hB);
        t3wr <= 1'b0;
        for (i = 0; i < 200 && adc !== 1'b1; i++) @(posedge clock_i);
        chk("adc", 16'h0001, {15'h0000, adc});
        cyc(2);
        #1;
        chk("timer", 16'h0002, t3o);
        chk("timer1", m1, t1o);
        pulse(2'b01);
        chk("shared", exp_v[0], cval[0]);
        $display("test special event done");
        vwd <= {16'h0008, 16'h0004};
        vwr <= 2'b11;
        setm(4'hC, 4'hC);
        vwr <= 2'b00;
        cyc(40);
        hi0 = 0;
        hi1 = 0;
        repeat (16) begin
            @(posedge clock_i);
            hi0 += pwm[0];
            hi1 += pwm[1];
        end
        chk("pwm0", 16'h0004, 16'(hi0));
        chk("pwm1", 16'h0008, 16'(hi1));
        vwd <= {16'h0008, 16'h0030};
        vwr <= 2'b01;
        twd <= 16'h0000;
        t3wr <= 1'b1;
        setm(4'h8, 4'hC);
        vwr <= 2'b00;
        t3wr <= 1'b0;
        cyc(2);
        chk("cmp_lo", 16'h0000, {15'h0000, cmp[0]});
        cyc(60);
        chk("cmp_hi", 16'h0001, {15'h0000, cmp[0]});
        $display("test pwm compare done");
        conclude();
    end
endmodule // testbench

// >>> verilog/ict_capture_end.sv
// Two capture/compare/PWM units: standard (0) and enhanced (1)
`timescale 1ns/10ps
`include "ict_map.svh"
module ict_capture_end
    import ict_pkg::*;
(
    // Clock and reset
    input  logic                  clock_i,
    input  logic                  sys_rst_i,
    // Link to timers and CAN
    ict_link_if.capture_mp        link,
    // Per-unit control; frame_timestamp_select_i is one bit shared by both units
    input  logic [1:0][3:0]       capture_mode_select_i,
    input  logic [1:0]            timer_select_third_i,
    input  logic                  frame_timestamp_select_i,
    input  logic [1:0]            flag_clear_i,
    // Pin direction and port latch
    input  logic [1:0]            pin_direction_bit_i,
    input  logic [1:0]            port_latch_i,
    // Software write of value registers
    input  logic [1:0]            value_wr_i,
    input  logic [1:0][15:0]      value_wdata_i,
    // Results
    output logic [1:0][15:0]      capture_value_o,
    output logic [1:0]            capture_irq_flag_o,
    output logic [1:0]            compare_out_o,
    output logic [1:0]            pwm_out_o,
    output logic                  adc_start_o
);

    // ****************************************************************
    // Pin synchroniser and edge detect
    // ****************************************************************
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] level_prev_q;
    logic [1:0] level;
    logic [1:0] rise;
    logic [1:0] fall;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
        end else begin
            pin_s1_q <= link.capture_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Output-configured pin follows the port latch
    assign level = (pin_direction_bit_i & pin_s2_q) | (~pin_direction_bit_i & port_latch_i);

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            level_prev_q <= 2'h0;
        end else begin
            level_prev_q <= level;
        end
    end

    assign rise = level & ~level_prev_q;
    assign fall = ~level & level_prev_q;

    // ****************************************************************
    // Per-unit logic
    // ****************************************************************
    logic [1:0] sev_first;
    logic [1:0] sev_third;

    genvar u;
    generate
        for (u = 0; u < 2; u = u + 1) begin : g_unit
            ict_mode_t  mode;
            ict_word_t  tbase;
            ict_pscnt_t ps_last;
            ict_pscnt_t ps_cnt_q;
            ict_word_t  value_q;
            ict_byte_t  duty_q;
            ict_mode_t  mode_prev_q;
            logic       is_cap;
            logic       is_cmp;
            logic       is_pwm;
            logic       event_in;
            logic       cap_hit;
            logic       cmp_hit;
            logic       match_prev_q;
            logic       flag_q;
            logic       cmp_out_q;
            logic       pwm_q;

            assign mode   = capture_mode_select_i[u];
            assign is_cap = (mode[3:2] == `ICT_GRP_CAPTURE);
            assign is_cmp = (mode[3:2] == `ICT_GRP_COMPARE) || (mode == `ICT_MODE_CMP_TOGGLE);
            assign is_pwm = (mode[3:2] == `ICT_GRP_PWM);

            // Time base per unit; units choose freely and may share
            assign tbase = timer_select_third_i[u] ? link.third_timer
                                                   : link.first_timer;

            // Frame signal replaces the pin when timestamping
            always_comb begin
                if (frame_timestamp_select_i) begin
                    event_in = link.frame_rx;
                end else if (mode == `ICT_MODE_CAP_FALL) begin
                    event_in = fall[u];
                end else begin
                    event_in = rise[u];
                end
            end

            always_comb begin
                case (mode[1:0])
                    2'h2:    ps_last = `ICT_PS_LAST_4;
                    2'h3:    ps_last = `ICT_PS_LAST_16;
                    default: ps_last = `ICT_PS_LAST_1;
                endcase
            end

            // Counter survives prescaler changes; >= catches a partial count
            assign cap_hit = is_cap && event_in && (ps_cnt_q >= ps_last);

            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    ps_cnt_q <= 4'h0;
                end else if (!is_cap) begin
                    ps_cnt_q <= 4'h0;
                end else if (event_in) begin
                    ps_cnt_q <= cap_hit ? 4'h0 : ps_cnt_q + 4'h1;
                end
            end

            // Capture wins over a software write
            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    value_q <= `ICT_VALUE_RST;
                end else if (cap_hit) begin
                    value_q <= tbase;
                end else if (value_wr_i[u]) begin
                    value_q <= value_wdata_i[u];
                end
            end

            // Compare fires once per match entry
            assign cmp_hit = is_cmp && (value_q == tbase) && !match_prev_q;

            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    match_prev_q <= 1'b0;
                    mode_prev_q  <= `ICT_MODE_OFF;
                end else begin
                    match_prev_q <= is_cmp && (value_q == tbase);
                    mode_prev_q  <= mode;
                end
            end

            // Set wins over clear
            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    flag_q <= 1'b0;
                end else if (cap_hit || cmp_hit) begin
                    flag_q <= 1'b1;
                end else if (flag_clear_i[u]) begin
                    flag_q <= 1'b0;
                end
            end

            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    cmp_out_q <= 1'b0;
                end else if (mode == `ICT_MODE_OFF) begin
                    cmp_out_q <= 1'b0;
                end else if (mode != mode_prev_q) begin
                    cmp_out_q <= (mode == `ICT_MODE_CMP_SETLO);
                end else if (cmp_hit) begin
                    if (mode == `ICT_MODE_CMP_SETHI) begin
                        cmp_out_q <= 1'b1;
                    end else if (mode == `ICT_MODE_CMP_SETLO) begin
                        cmp_out_q <= 1'b0;
                    end else if (mode == `ICT_MODE_CMP_TOGGLE) begin
                        cmp_out_q <= ~cmp_out_q;
                    end
                end
            end

            // Trigger resets this unit's own time base
            assign sev_first[u] = cmp_hit && (mode == `ICT_MODE_CMP_SPEV)
                                  && !timer_select_third_i[u];
            assign sev_third[u] = cmp_hit && (mode == `ICT_MODE_CMP_SPEV)
                                  && timer_select_third_i[u];

            // Duty reloads on the shared period, so both PWMs stay in step
            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    duty_q <= `ICT_PERIOD_RST;
                    pwm_q  <= 1'b0;
                end else begin
                    if (link.second_period_hit) begin
                        duty_q <= value_q[7:0];
                    end
                    pwm_q <= is_pwm && (link.second_timer < duty_q);
                end
            end

            assign capture_value_o[u]    = value_q;
            assign capture_irq_flag_o[u] = flag_q;
            assign compare_out_o[u]      = cmp_out_q;
            assign pwm_out_o[u]          = pwm_q;
        end
    endgenerate

    // ****************************************************************
    // Special event outputs
    // ****************************************************************
    logic first_reset_q;
    logic third_reset_q;
    logic adc_start_q;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            first_reset_q <= 1'b0;
            third_reset_q <= 1'b0;
            adc_start_q   <= 1'b0;
        end else begin
            first_reset_q <= |sev_first;
            third_reset_q <= |sev_third;
            adc_start_q   <= sev_first[1] | sev_third[1];
        end
    end

    assign link.first_timer_reset = first_reset_q;
    assign link.third_timer_reset = third_reset_q;
    assign adc_start_o            = adc_start_q;

endmodule // ict_capture_end

// >>> verilog/ict_link_if.sv
// Link between the capture units and the timer / CAN side
`timescale 1ns/10ps
interface ict_link_if;
    import ict_pkg::*;
    ict_word_t first_timer;
    ict_word_t third_timer;
    ict_byte_t second_timer;
    logic      second_period_hit;
    logic      frame_rx;
    logic [1:0] capture_pin;
    logic      first_timer_reset;
    logic      third_timer_reset;

    modport capture_mp (
        input  first_timer, third_timer, second_timer, second_period_hit,
        input  frame_rx, capture_pin,
        output first_timer_reset, third_timer_reset
    );
    modport timebase_mp (
        output first_timer, third_timer, second_timer, second_period_hit,
        output frame_rx, capture_pin,
        input  first_timer_reset, third_timer_reset
    );
endinterface

// >>> verilog/ict_map.svh
// Constant map for the input capture timebase pair
//
// Contract
// - Capture/compare use first/third timer, PWM second
// - Per-unit timer select bits choose timer
// - Both units active, may share one timer
// - Capturing units pick timers independently
// - Compare trigger resets timer seen by capturer; code resets the comparer's own selected timer
// - Either comparer resets; enhanced also starts conversion
// - Both PWMs share second timer period
// - Capture copies full 16-bit selected timer
// - Mode bits pick falling, rising, 4th, 16th
// - Capture sets flag; only software clears
// - New capture overwrites unread value
// - Output-configured pin write still captures
// - Software sets pin as input first
// - Software runs timer in synchronous mode
// - Mode change may raise false flag
// - Prescaler cleared when off or not capturing
// - Prescaler kept across prescaler setting changes
// - Stored CAN frame signals a capture event
// - Timestamp select replaces pin with frame signal
// - CAN source: every, every, 4th, 16th frame
// - Codes 0100 fall, 0101 rise, 0110, 0111
// - Code 0000 disables and clears state; code clears prescaler and compare output but keeps flag and value
`ifndef ICT_MAP_SVH
`define ICT_MAP_SVH

// ****************************************************************
// Mode codes
// ****************************************************************
`define ICT_MODE_OFF        4'h0
`define ICT_MODE_CMP_TOGGLE 4'h2
`define ICT_MODE_CAP_FALL   4'h4
`define ICT_MODE_CAP_RISE   4'h5
`define ICT_MODE_CAP_RISE4  4'h6
`define ICT_MODE_CAP_RISE16 4'h7
`define ICT_MODE_CMP_SETHI  4'h8
`define ICT_MODE_CMP_SETLO  4'h9
`define ICT_MODE_CMP_SWIRQ  4'hA
`define ICT_MODE_CMP_SPEV   4'hB

// ****************************************************************
// Mode field groups (bits 3:2)
// ****************************************************************
`define ICT_GRP_CAPTURE     2'h1
`define ICT_GRP_COMPARE     2'h2
`define ICT_GRP_PWM         2'h3

// ****************************************************************
// Prescaler terminal counts (count minus one)
// ****************************************************************
`define ICT_PS_LAST_1       4'h0
`define ICT_PS_LAST_4       4'h3
`define ICT_PS_LAST_16      4'hF

// ****************************************************************
// Reset values
// ****************************************************************
`define ICT_TIMER_RST       16'h0000
`define ICT_PERIOD_RST      8'h00
`define ICT_VALUE_RST       16'h0000

`endif

// >>> verilog/ict_pkg.sv
// Types shared by both ends of the capture timebase link
package ict_pkg;
    typedef logic [15:0] ict_word_t;
    typedef logic [7:0]  ict_byte_t;
    typedef logic [3:0]  ict_mode_t;
    typedef logic [3:0]  ict_pscnt_t;
endpackage

// >>> verilog/ict_timebase_end.sv
// Timer and CAN side feeding the capture units
`timescale 1ns/10ps
`include "ict_map.svh"
module ict_timebase_end
    import ict_pkg::*;
#(
    parameter int RX_BUFS = 2
)
(
    // Clock and reset
    input  logic                  clock_i,
    input  logic                  sys_rst_i,
    // Link to capture units
    ict_link_if.timebase_mp       link,
    // Timer control
    input  logic                  first_timer_on_i,
    input  logic                  second_timer_on_i,
    input  logic                  third_timer_on_i,
    input  logic [7:0]            second_period_i,
    // Timer writes
    input  logic                  first_timer_wr_i,
    input  logic                  third_timer_wr_i,
    input  logic [15:0]           timer_wdata_i,
    // CAN receive buffers and pins
    input  logic [RX_BUFS-1:0]    frame_stored_i,
    input  logic [1:0]            pin_level_i,
    // Observed values
    output logic [15:0]           first_timer_o,
    output logic [15:0]           third_timer_o
);

    // ****************************************************************
    // Timers
    // ****************************************************************
    ict_word_t  first_q;
    ict_word_t  third_q;
    ict_byte_t  second_q;
    logic       period_hit_q;
    logic       frame_q;
    logic [1:0] pin_q;

    // A write takes precedence over a special event reset
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            first_q <= `ICT_TIMER_RST;
        end else if (first_timer_wr_i) begin
            first_q <= timer_wdata_i;
        end else if (link.first_timer_reset) begin
            first_q <= `ICT_TIMER_RST;
        end else if (first_timer_on_i) begin
            first_q <= first_q + 16'h0001;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            third_q <= `ICT_TIMER_RST;
        end else if (third_timer_wr_i) begin
            third_q <= timer_wdata_i;
        end else if (link.third_timer_reset) begin
            third_q <= `ICT_TIMER_RST;
        end else if (third_timer_on_i) begin
            third_q <= third_q + 16'h0001;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            second_q     <= `ICT_PERIOD_RST;
            period_hit_q <= 1'b0;
        end else begin
            period_hit_q <= 1'b0;
            if (second_timer_on_i) begin
                if (second_q == second_period_i) begin
                    second_q     <= `ICT_PERIOD_RST;
                    period_hit_q <= 1'b1;
                end else begin
                    second_q <= second_q + 8'h01;
                end
            end
        end
    end

    // ****************************************************************
    // Frame event and pins
    // ****************************************************************
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_q <= 1'b0;
            pin_q   <= 2'h0;
        end else begin
            frame_q <= |frame_stored_i;
            pin_q   <= pin_level_i;
        end
    end

    assign link.first_timer       = first_q;
    assign link.third_timer       = third_q;
    assign link.second_timer      = second_q;
    assign link.second_period_hit = period_hit_q;
    assign link.frame_rx          = frame_q;
    assign link.capture_pin       = pin_q;
    assign first_timer_o          = first_q;
    assign third_timer_o          = third_q;

endmodule // ict_timebase_end
